// >>> hdl/tfa_pkg.sv
/*
 * Shared constants for the temperature result and alert back end: register
 * offsets, reset values, configuration bit positions and timing.
 * Assumes a 200 MHz core clock and a serial management bus slave front end.
 */
package tfa_pkg;

	// ---------------------------------------------------------------
	// Bus addresses
	// ---------------------------------------------------------------
	// Own slave address; arbitrary value
	localparam logic [6:0] SLAVE_ADDR = 7'h4c;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] RD_INT_HI = 8'h00;
	localparam logic [7:0] RD_REM_HI = 8'h01;
	localparam logic [7:0] RD_STATUS = 8'h02;
	localparam logic [7:0] RD_CFG = 8'h03;
	localparam logic [7:0] RD_RATE = 8'h04;
	localparam logic [7:0] RD_INT_HLIM = 8'h05;
	localparam logic [7:0] RD_INT_LLIM = 8'h06;
	localparam logic [7:0] RD_REM_HLIM_H = 8'h07;
	localparam logic [7:0] RD_REM_LLIM_H = 8'h08;
	localparam logic [7:0] WR_CFG = 8'h09;
	localparam logic [7:0] WR_RATE = 8'h0a;
	localparam logic [7:0] WR_INT_HLIM = 8'h0b;
	localparam logic [7:0] WR_INT_LLIM = 8'h0c;
	localparam logic [7:0] WR_REM_HLIM_H = 8'h0d;
	localparam logic [7:0] WR_REM_LLIM_H = 8'h0e;
	localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
	localparam logic [7:0] RD_REM_LO = 8'h10;
	localparam logic [7:0] REG_SCRATCH1 = 8'h11;
	localparam logic [7:0] REG_SCRATCH2 = 8'h12;
	localparam logic [7:0] REG_REM_HLIM_L = 8'h13;
	localparam logic [7:0] REG_REM_LLIM_L = 8'h14;
	localparam logic [7:0] REG_REM_THERMAL_TRIP_OUTPUT = 8'h19;
	localparam logic [7:0] REG_INT_THERMAL_TRIP_OUTPUT = 8'h20;
	localparam logic [7:0] REG_HYST = 8'h21;
	localparam logic [7:0] REG_CONSEC = 8'h22;
	localparam logic [7:0] REG_IDEALITY = 8'h27;
	localparam logic [7:0] RD_INT_LO = 8'h29;
	localparam logic [7:0] RD_PRODUCT = 8'hfd;
	localparam logic [7:0] RD_MAKER = 8'hfe;
	localparam logic [7:0] RD_REVISION = 8'hff;

	// ---------------------------------------------------------------
	// Reset and identity values
	// ---------------------------------------------------------------
	localparam logic [7:0] RATE_RST = 8'h08;
	localparam logic [7:0] LIM85_RST = 8'h55;
	localparam logic [7:0] HYST_RST = 8'h0a;
	localparam logic [7:0] CONSEC_RST = 8'h01;
	localparam logic [5:0] IDEALITY_RST = 6'h12;
	// Identity values are arbitrary
	localparam logic [7:0] PRODUCT_CODE = 8'h5a;
	localparam logic [7:0] MAKER_CODE = 8'ha5;
	localparam logic [7:0] REVISION_CODE = 8'h07;

	// ---------------------------------------------------------------
	// Configuration fields and result format
	// ---------------------------------------------------------------
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STBY_BIT = 6;
	localparam int CFG_TRIP2_BIT = 5;
	localparam int CFG_EXT_BIT = 2;
	localparam logic signed [13:0] EXT_OFFSET = 14'sh0200;
	localparam logic signed [13:0] DEF_TOP = 14'sh03f8;
	localparam logic signed [13:0] EXT_TOP = 14'sh07f8;
	localparam logic [10:0] DEF_SAT = 11'h3f8;
	localparam logic [10:0] EXT_SAT = 11'h7f8;
	localparam logic [7:0] RATE_MAX = 8'h09;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CORE_CLK_NS = 5;
	localparam int CONV_PERIOD_NS = 1000000000;
	localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS / CORE_CLK_NS;

endpackage

// >>> hdl/tfa_link.sv
/*
 * Serial management bus slave engine on the link clock.
 * Assumes the bus clock and data pins are asynchronous and oversampled,
 * and that the core answers a read request within one bus bit time.
 */
`timescale 1ns/1ps
module tfa_link
	import tfa_pkg::*;
(
	// Clock and reset
	input wire logic link_clk_i,
	input wire logic sys_rst_i,
	// Bus pins
	input wire logic smb_clk_i,
	input wire logic smb_data_i,
	output logic smb_data_o,
	output logic smb_data_oe_n_o,
	// Requests towards the core
	output logic req_tg_o,
	output logic req_wr_o,
	output logic req_ara_o,
	output logic [7:0] req_addr_o,
	output logic [7:0] req_data_o,
	// Answers from the core
	input wire logic ack_tg_i,
	input wire logic [7:0] rdat_i,
	input wire logic alert_lvl_i
);

	typedef enum logic [8:0] {
		L_IDLE = 9'h001,
		L_ADDR = 9'h002,
		L_ACKA = 9'h004,
		L_CMD = 9'h008,
		L_ACKC = 9'h010,
		L_WDAT = 9'h020,
		L_ACKD = 9'h040,
		L_RDAT = 9'h080,
		L_RACK = 9'h100
	} tfa_lst_t;

	typedef struct packed {
		logic [1:0] rs;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] ack_s;
		logic [1:0] alr_s;
		tfa_lst_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic oe_n;
		logic req_tg;
		logic req_wr;
		logic req_ara;
		logic [7:0] req_addr;
		logic [7:0] req_data;
	} tfa_link_t;

	tfa_link_t r, n;
	logic rise, fall, start, stop, match, is_ara;

	always_comb
	begin
		n = r;
		n.rs = {r.rs[0], sys_rst_i};
		n.scl_s = {r.scl_s[1:0], smb_clk_i};
		n.sda_s = {r.sda_s[1:0], smb_data_i};
		n.ack_s = {r.ack_s[0], ack_tg_i};
		n.alr_s = {r.alr_s[0], alert_lvl_i};
		rise = r.scl_s[1] & ~r.scl_s[2];
		fall = ~r.scl_s[1] & r.scl_s[2];
		start = r.scl_s[1] & r.scl_s[2] & r.sda_s[2] & ~r.sda_s[1];
		stop = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[2] & r.sda_s[1];
		is_ara = (r.sh[7:1] == ALERT_RESP_ADDR);
		match = (r.sh[7:1] == SLAVE_ADDR) | (is_ara & r.sh[0] & r.alr_s[1]);
		if (r.rs[1])
		begin
			n.st = L_IDLE;
			n.cnt = 4'h0;
			n.sh = 8'h00;
			n.ptr = 8'h00;
			n.oe_n = 1'b1;
			n.req_tg = 1'b0;
			n.req_wr = 1'b0;
			n.req_ara = 1'b0;
			n.req_addr = 8'h00;
			n.req_data = 8'h00;
		end
		else if (start)
		begin
			n.st = L_ADDR;
			n.cnt = 4'h0;
			n.oe_n = 1'b1;
		end
		else if (stop)
		begin
			n.st = L_IDLE;
			n.oe_n = 1'b1;
		end
		else
		begin
			unique case (r.st)
				L_IDLE:
				begin
					n.oe_n = 1'b1;
				end
				L_ADDR, L_CMD, L_WDAT:
				begin
					if (rise)
					begin
						n.sh = {r.sh[6:0], r.sda_s[1]};
						n.cnt = r.cnt + 4'h1;
					end
					else if (fall && r.cnt == 4'h8)
					begin
						n.oe_n = 1'b0;
						if (r.st == L_ADDR)
						begin
							n.st = match ? L_ACKA : L_IDLE;
							n.oe_n = ~match;
							if (match && r.sh[0])
							begin
								n.req_tg = ~r.req_tg;
								n.req_wr = 1'b0;
								n.req_ara = is_ara;
								n.req_addr = r.ptr;
							end
						end
						else if (r.st == L_CMD)
						begin
							n.ptr = r.sh;
							n.st = L_ACKC;
						end
						else
						begin
							n.req_tg = ~r.req_tg;
							n.req_wr = 1'b1;
							n.req_ara = 1'b0;
							n.req_addr = r.ptr;
							n.req_data = r.sh;
							n.st = L_ACKD;
						end
					end
				end
				L_ACKA:
				begin
					if (fall)
					begin
						n.cnt = 4'h0;
						if (r.sh[0])
						begin
							n.st = L_RDAT;
							n.sh = (r.ack_s[1] == r.req_tg) ? rdat_i : 8'hff;
							n.oe_n = (r.ack_s[1] == r.req_tg) ? rdat_i[7] : 1'b1;
						end
						else
						begin
							n.st = L_CMD;
							n.oe_n = 1'b1;
						end
					end
				end
				L_ACKC:
				begin
					if (fall)
					begin
						n.cnt = 4'h0;
						n.oe_n = 1'b1;
						n.st = L_WDAT;
					end
				end
				L_ACKD, L_RACK:
				begin
					if (fall)
					begin
						n.oe_n = 1'b1;
						n.st = L_IDLE;
					end
				end
				L_RDAT:
				begin
					if (rise)
						n.cnt = r.cnt + 4'h1;
					else if (fall)
					begin
						if (r.cnt == 4'h8)
						begin
							n.oe_n = 1'b1;
							n.st = L_RACK;
						end
						else
						begin
							n.oe_n = r.sh[6];
							n.sh = {r.sh[6:0], 1'b1};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		r <= n;
	end

	assign smb_data_o = 1'b0;
	assign smb_data_oe_n_o = r.oe_n;
	assign req_tg_o = r.req_tg;
	assign req_wr_o = r.req_wr;
	assign req_ara_o = r.req_ara;
	assign req_addr_o = r.req_addr;
	assign req_data_o = r.req_data;

endmodule

// >>> hdl/tfa_core.sv
/*
 * Temperature result formatting, result registers, conversion scheduling,
 * limit comparison, alert and trip outputs of a two-zone monitor.
 * Assumes an external converter that answers each start with one done pulse
 * carrying a signed result in eighths of a degree, on the core clock.
 */
`timescale 1ns/1ps

module tfa_core
	import tfa_pkg::*;
#(
	parameter int CONV_CYC = CONV_PERIOD_CYC
)
(
	// Clocks and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	// Bus pins
	input wire logic smb_clk_i,
	input wire logic smb_data_i,
	output logic smb_data_o,
	output logic smb_data_oe_n_o,
	// Open-drain outputs
	output logic alert_or_second_trip_output_o,
	output logic alert_or_second_trip_output_oe_n_o,
	output logic thermal_trip_output_o,
	output logic thermal_trip_output_oe_n_o,
	// Converter
	output logic conv_start_o,
	output logic conv_zone_o,
	output logic [5:0] ideality_o,
	input wire logic adc_done_i,
	input wire logic signed [12:0] adc_temp_i
);

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] rate;
		logic [7:0] ihl;
		logic [7:0] ill;
		logic [7:0] rhlh;
		logic [7:0] rllh;
		logic [7:0] rhll;
		logic [7:0] rlll;
		logic [7:0] rth;
		logic [7:0] ith;
		logic [7:0] hyst;
		logic [7:0] cons;
		logic [5:0] ideal;
		logic [7:0] scr1;
		logic [7:0] scr2;
		logic [10:0] ival;
		logic [10:0] rval;
		logic [2:0] ilo_sh;
		logic [2:0] rlo_sh;
		logic ifrz;
		logic rfrz;
		logic [31:0] tmr;
		logic [1:0] shots;
		logic busy;
		logic start;
		logic zone;
		logic ith_st;
		logic rth_st;
		logic t2i;
		logic t2r;
		logic alert;
		logic alert_oe_n;
		logic thermal_trip_output_oe_n;
		logic [2:0] rq_s;
		logic ack_tg;
		logic [7:0] rdat;
	} tfa_core_t;

	tfa_core_t r, n;
	logic req_tg, req_wr, req_ara;
	logic [7:0] req_addr, req_data;
	logic req_ev, ool, i_hi, i_lo, r_hi, r_lo;
	logic [7:0] status, rate_c;
	logic [31:0] period;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [10:0] fmt_result(input logic signed [12:0] raw,
		input logic ext, input logic intz);
		logic signed [13:0] v;
		logic [10:0] res;
		v = {raw[12], raw} + (ext ? EXT_OFFSET : 14'sh0000);
		if (v <= 14'sh0000)
			res = 11'h000;
		else if (!ext && v >= DEF_TOP)
			res = DEF_SAT;
		else if (ext && v >= EXT_TOP)
			res = EXT_SAT;
		else
			res = v[10:0];
		if (intz)
			res[1:0] = 2'b00;
		return res;
	endfunction

	// Hysteresis floor, saturating at zero
	function automatic logic [7:0] floor_sub(input logic [7:0] lim, input logic [7:0] h);
		return (lim > h) ? lim - h : 8'h00;
	endfunction

	function automatic logic trip_next(input logic st, input logic [7:0] val,
		input logic [7:0] lim, input logic [7:0] h);
		if (val > lim)
			return 1'b1;
		else if (val < floor_sub(lim, h))
			return 1'b0;
		else
			return st;
	endfunction

	// ---------------------------------------------------------------
	// Link engine
	// ---------------------------------------------------------------
	tfa_link u_link (
		.link_clk_i(link_clk_i),
		.sys_rst_i(sys_rst_i),
		.smb_clk_i(smb_clk_i),
		.smb_data_i(smb_data_i),
		.smb_data_o(smb_data_o),
		.smb_data_oe_n_o(smb_data_oe_n_o),
		.req_tg_o(req_tg),
		.req_wr_o(req_wr),
		.req_ara_o(req_ara),
		.req_addr_o(req_addr),
		.req_data_o(req_data),
		.ack_tg_i(r.ack_tg),
		.rdat_i(r.rdat),
		.alert_lvl_i(~r.alert_oe_n)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.rq_s = {r.rq_s[1:0], req_tg};
		req_ev = r.rq_s[2] ^ r.rq_s[1];
		i_hi = r.ival[10:3] > r.ihl;
		i_lo = r.ival[10:3] < r.ill;
		r_hi = r.rval > {r.rhlh, r.rhll[7:5]};
		r_lo = r.rval < {r.rllh, r.rlll[7:5]};
		ool = i_hi | i_lo | r_hi | r_lo;
		status = {r.busy, i_hi, i_lo, r_hi, r_lo, 1'b0, r.rth_st, r.ith_st};
		rate_c = (r.rate > RATE_MAX) ? RATE_MAX : r.rate;
		period = 32'(CONV_CYC) >> rate_c;
		if (period == 32'h0)
			period = 32'h1;
		n.start = 1'b0;

		// Conversion scheduling
		if (r.tmr != 32'h0)
			n.tmr = r.tmr - 32'h1;
		if (!r.busy && ((!r.cfg[CFG_STBY_BIT] && r.tmr == 32'h0) || r.shots != 2'b00))
		begin
			n.start = 1'b1;
			n.busy = 1'b1;
			n.zone = ~r.zone;
			n.tmr = period;
			if (r.shots != 2'b00)
				n.shots = r.shots - 2'b01;
		end
		if (r.busy && adc_done_i)
		begin
			n.busy = 1'b0;
			if (r.zone)
				n.rval = fmt_result(adc_temp_i, r.cfg[CFG_EXT_BIT], 1'b0);
			else
				n.ival = fmt_result(adc_temp_i, r.cfg[CFG_EXT_BIT], 1'b1);
		end

		// Thermal and second trip states
		n.ith_st = trip_next(r.ith_st, r.ival[10:3], r.ith, r.hyst);
		n.rth_st = trip_next(r.rth_st, r.rval[10:3], r.rth, r.hyst);
		n.t2i = trip_next(r.t2i, r.ival[10:3], r.ihl, r.hyst);
		n.t2r = trip_next(r.t2r, r.rval[10:3], r.rhlh, r.hyst);

		// Register access from the link
		if (req_ev)
		begin
			n.ack_tg = ~r.ack_tg;
			if (req_wr)
			begin
				unique case (req_addr)
					WR_CFG: n.cfg = req_data;
					WR_RATE: n.rate = req_data;
					WR_INT_HLIM: n.ihl = req_data;
					WR_INT_LLIM: n.ill = req_data;
					WR_REM_HLIM_H: n.rhlh = req_data;
					WR_REM_LLIM_H: n.rllh = req_data;
					WR_ONE_SHOT: n.shots = 2'b10;
					REG_SCRATCH1: n.scr1 = req_data;
					REG_SCRATCH2: n.scr2 = req_data;
					REG_REM_HLIM_L: n.rhll = req_data;
					REG_REM_LLIM_L: n.rlll = req_data;
					REG_REM_THERMAL_TRIP_OUTPUT: n.rth = req_data;
					REG_INT_THERMAL_TRIP_OUTPUT: n.ith = req_data;
					REG_HYST: n.hyst = req_data;
					REG_CONSEC: n.cons = req_data;
					REG_IDEALITY: n.ideal = req_data[5:0];
					default: n.cfg = r.cfg;
				endcase
			end
			else if (req_ara)
			begin
				n.rdat = {SLAVE_ADDR, 1'b0};
				if (!ool)
					n.alert = 1'b0;
			end
			else
			begin
				unique case (req_addr)
					RD_INT_HI:
					begin
						n.rdat = r.ival[10:3];
						n.ifrz = 1'b1;
						n.ilo_sh = r.ival[2:0];
					end
					RD_REM_HI:
					begin
						n.rdat = r.rval[10:3];
						n.rfrz = 1'b1;
						n.rlo_sh = r.rval[2:0];
					end
					RD_INT_LO:
					begin
						n.rdat = {r.ifrz ? r.ilo_sh : r.ival[2:0], 5'h00};
						n.ifrz = 1'b0;
					end
					RD_REM_LO:
					begin
						n.rdat = {r.rfrz ? r.rlo_sh : r.rval[2:0], 5'h00};
						n.rfrz = 1'b0;
					end
					RD_STATUS: n.rdat = status;
					RD_CFG: n.rdat = r.cfg;
					RD_RATE: n.rdat = r.rate;
					RD_INT_HLIM: n.rdat = r.ihl;
					RD_INT_LLIM: n.rdat = r.ill;
					RD_REM_HLIM_H: n.rdat = r.rhlh;
					RD_REM_LLIM_H: n.rdat = r.rllh;
					REG_SCRATCH1: n.rdat = r.scr1;
					REG_SCRATCH2: n.rdat = r.scr2;
					REG_REM_HLIM_L: n.rdat = r.rhll;
					REG_REM_LLIM_L: n.rdat = r.rlll;
					REG_REM_THERMAL_TRIP_OUTPUT: n.rdat = r.rth;
					REG_INT_THERMAL_TRIP_OUTPUT: n.rdat = r.ith;
					REG_HYST: n.rdat = r.hyst;
					REG_CONSEC: n.rdat = r.cons;
					REG_IDEALITY: n.rdat = {2'b00, r.ideal};
					RD_PRODUCT: n.rdat = PRODUCT_CODE;
					RD_MAKER: n.rdat = MAKER_CODE;
					RD_REVISION: n.rdat = REVISION_CODE;
					default: n.rdat = 8'h00;
				endcase
			end
		end

		// Alert latch: a new out-of-limit result wins over a release
		if (ool && !r.cfg[CFG_MASK_BIT])
			n.alert = 1'b1;
		if (r.cfg[CFG_TRIP2_BIT])
			n.alert_oe_n = ~(r.t2i | r.t2r);
		else
			n.alert_oe_n = ~r.alert;
		n.thermal_trip_output_oe_n = ~(r.ith_st | r.rth_st);

		if (sys_rst_i)
		begin
			n = '0;
			n.rate = RATE_RST;
			n.ihl = LIM85_RST;
			n.rhlh = LIM85_RST;
			n.rth = LIM85_RST;
			n.ith = LIM85_RST;
			n.hyst = HYST_RST;
			n.cons = CONSEC_RST;
			n.ideal = IDEALITY_RST;
			n.alert_oe_n = 1'b1;
			n.thermal_trip_output_oe_n = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		r <= n;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign alert_or_second_trip_output_o = 1'b0;
	assign alert_or_second_trip_output_oe_n_o = r.alert_oe_n;
	assign thermal_trip_output_o = 1'b0;
	assign thermal_trip_output_oe_n_o = r.thermal_trip_output_oe_n;
	assign conv_start_o = r.start;
	assign conv_zone_o = r.zone;
	assign ideality_o = r.ideal;

endmodule

// >>> sim/tfa_core_assertions.sv
/* Port checker for tfa_core.
   Assumes a bind from the bench top, run mode at rate 8 and no standby. */
`timescale 1ns/1ps
module tfa_core_assertions
	import tfa_pkg::*;
#(
	parameter int CONV_CYC = 2000
)
(
	// Clocks and reset
	input wire logic core_clk_i,
	input wire logic link_clk_i,
	input wire logic sys_rst_i,
	// Watched pins
	input wire logic smb_clk_i,
	input wire logic smb_data_o,
	input wire logic smb_data_oe_n_o,
	input wire logic alert_or_second_trip_output_o,
	input wire logic alert_or_second_trip_output_oe_n_o,
	input wire logic thermal_trip_output_o,
	input wire logic thermal_trip_output_oe_n_o,
	input wire logic conv_start_o,
	input wire logic [5:0] ideality_o,
	input wire logic adc_done_i
);
	localparam int GAP_MAX = 40;
	property p_start_pulse;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		conv_start_o |=> !conv_start_o ##1 !conv_start_o;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not a lone pulse");
	property p_conv_gap;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		conv_start_o |-> ##[1:GAP_MAX] conv_start_o;
	endproperty
	a_conv_gap: assert property (p_conv_gap) else $error("run mode stopped converting");
	property p_ideal_rst;
		@(posedge core_clk_i) sys_rst_i |=> ideality_o == IDEALITY_RST;
	endproperty
	a_ideal_rst: assert property (p_ideal_rst) else $error("ideality reset value wrong");
	property p_oe_rst;
		@(posedge core_clk_i)
		sys_rst_i |=> alert_or_second_trip_output_oe_n_o && thermal_trip_output_oe_n_o;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("output pulled during reset");
	property p_od_low;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!alert_or_second_trip_output_o && !thermal_trip_output_o;
	endproperty
	a_od_low: assert property (p_od_low) else $error("open drain driven high");
	property p_sda_od;
		@(posedge link_clk_i) disable iff (sys_rst_i) !smb_data_o;
	endproperty
	a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
	property p_sda_change;
		@(posedge link_clk_i) disable iff (sys_rst_i)
		$changed(smb_data_oe_n_o) |-> !smb_clk_i;
	endproperty
	a_sda_change: assert property (p_sda_change) else $error("data moved with clock high");
	property p_thermal_trip_output_cause;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(thermal_trip_output_oe_n_o) |-> $past(adc_done_i, 1) || $past(adc_done_i, 2)
			|| $past(adc_done_i, 3) || $past(adc_done_i, 4) || $past(adc_done_i, 5);
	endproperty
	a_thermal_trip_output_cause: assert property (p_thermal_trip_output_cause) else $error("trip without result");
	c_conv: cover property (@(posedge core_clk_i) conv_start_o);
	c_alert: cover property (@(posedge core_clk_i) $fell(alert_or_second_trip_output_oe_n_o));
	c_thermal_trip_output: cover property (@(posedge core_clk_i) $fell(thermal_trip_output_oe_n_o));
	c_sda: cover property (@(posedge link_clk_i) !smb_data_oe_n_o);
endmodule

// >>> sim/tfa_host_model.sv
/* Bus host model: bit-banged master, quarter bit of three link clocks.
   Assumes a pull-up on data; clock stands high between frames. */
`timescale 1ns/1ps
module tfa_host_model
	import tfa_pkg::*;
(
	// Link clock
	input wire logic link_clk_i,
	// Bus pins
	input wire logic smb_data_oe_n_i,
	output logic smb_clk_o,
	output logic smb_data_o
);
	logic scl_r = 1'b1;
	logic sda_r = 1'b1;
	// Wire level: low while either side pulls
	assign smb_data_o = sda_r & smb_data_oe_n_i;
	assign smb_clk_o = scl_r;
	task automatic tick;
		repeat (3) @(posedge link_clk_i);
	endtask
	task automatic start;
		sda_r <= 1'b1;
		tick();
		scl_r <= 1'b1;
		tick();
		sda_r <= 1'b0;
		tick();
		scl_r <= 1'b0;
		tick();
	endtask
	task automatic sbit(input logic b, output logic r);
		sda_r <= b;
		tick();
		scl_r <= 1'b1;
		tick();
		r = smb_data_o;
		tick();
		scl_r <= 1'b0;
		tick();
	endtask
	task automatic sbyte(input logic [7:0] d, output logic [7:0] q, output logic nak);
		for (int i = 7; i >= 0; i--)
			sbit(d[i], q[i]);
		sbit(1'b1, nak);
	endtask
	task automatic xfer(input logic ara, input logic wr, input logic [7:0] cmd,
		input logic [7:0] d, output logic [7:0] q, output logic nak);
		logic [7:0] junk;
		logic a0;
		logic a1;
		logic a2;
		a1 = 1'b0;
		a2 = 1'b0;
		start();
		if (ara)
			sbyte({ALERT_RESP_ADDR, 1'b1}, junk, a0);
		else
		begin
			sbyte({SLAVE_ADDR, 1'b0}, junk, a0);
			sbyte(cmd, junk, a1);
			if (!wr)
			begin
				start();
				sbyte({SLAVE_ADDR, 1'b1}, junk, a2);
			end
		end
		q = 8'h00;
		if (wr)
			sbyte(d, junk, a2);
		else
			sbyte(8'hff, q, junk[0]);
		sda_r <= 1'b0;
		tick();
		scl_r <= 1'b1;
		tick();
		sda_r <= 1'b1;
		tick();
		nak = a0 | a1 | a2;
	endtask
endmodule

// >>> sim/tfa_core_tb_top.sv
/* Self-checking bench for tfa_core with host and converter models.
   Assumes the design package and a shortened conversion period. */
`timescale 1ns/1ps
module tfa_core_tb_top
	import tfa_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic adc_done_i = 1'b0;
	logic signed [12:0] adc_temp_i = 13'sh0000;
	logic signed [12:0] rem_t = 13'sh0000;
	logic signed [12:0] int_t = 13'sh0000;
	logic smb_clk;
	logic smb_wire;
	logic sda_oe_n;
	logic alert_oe_n;
	logic thermal_trip_output_oe_n;
	logic conv_start;
	logic conv_zone;
	logic zone_prev;
	logic [5:0] ideality;
	logic [7:0] q;
	logic nak;
	int errors = 0;
	int samples_checked = 0;
	int conv_cnt = 0;
	initial forever #2.5 core_clk_i = ~core_clk_i;
	initial
	begin
		#7;
		forever #24 link_clk_i = ~link_clk_i;
	end
	tfa_core #(.CONV_CYC(2000)) u_tfa_core (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.link_clk_i(link_clk_i),
		.smb_clk_i(smb_clk),
		.smb_data_i(smb_wire),
		.smb_data_o(),
		.smb_data_oe_n_o(sda_oe_n),
		.alert_or_second_trip_output_o(),
		.alert_or_second_trip_output_oe_n_o(alert_oe_n),
		.thermal_trip_output_o(),
		.thermal_trip_output_oe_n_o(thermal_trip_output_oe_n),
		.conv_start_o(conv_start),
		.conv_zone_o(conv_zone),
		.ideality_o(ideality),
		.adc_done_i(adc_done_i),
		.adc_temp_i(adc_temp_i)
	);
	tfa_host_model u_tfa_host_model (
		.link_clk_i(link_clk_i),
		.smb_data_oe_n_i(sda_oe_n),
		.smb_clk_o(smb_clk),
		.smb_data_o(smb_wire)
	);
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [10:0] fmt(input logic signed [12:0] t, input logic ext);
		logic signed [13:0] v;
		v = ext ? t + 14'sd512 : t;
		if (v <= 0)
			return 11'h000;
		if (v >= (ext ? 2040 : 1016))
			return ext ? 11'h7f8 : 11'h3f8;
		return v[10:0];
	endfunction
	// Converter: random latency, one result per start
	always @(posedge core_clk_i)
	begin
		if (conv_start === 1'b1)
		begin
			repeat (1 + $urandom % 3) @(posedge core_clk_i);
			if (conv_cnt > 0)
				chk({10'h0, conv_zone}, {10'h0, ~zone_prev});
			zone_prev = conv_zone;
			adc_temp_i <= conv_zone ? rem_t : int_t;
			adc_done_i <= 1'b1;
			@(posedge core_clk_i);
			adc_done_i <= 1'b0;
			conv_cnt++;
		end
	end
	task automatic bus(input logic ara, input logic wr, input logic [7:0] cmd,
		input logic [7:0] d);
		u_tfa_host_model.xfer(ara, wr, cmd, d, q, nak);
		chk({10'h0, nak}, 11'h000);
	endtask
	task automatic settle;
		int c;
		c = conv_cnt;
		for (int i = 0; i < 600 && conv_cnt < c + 6; i++)
			@(posedge core_clk_i);
		if (conv_cnt < c + 6)
		begin
			errors++;
			summarize();
		end
		#1;
	endtask
	task automatic chkcase(input logic ext, input logic lo_int);
		logic [10:0] e;
		settle();
		e = fmt(rem_t, ext);
		bus(1'b0, 1'b0, RD_REM_HI, 8'h00);
		chk({3'h0, q}, {3'h0, e[10:3]});
		bus(1'b0, 1'b0, RD_REM_LO, 8'h00);
		chk({3'h0, q}, {3'h0, e[2:0], 5'h00});
		e = fmt(int_t, ext) & 11'h7fc;
		bus(1'b0, 1'b0, RD_INT_HI, 8'h00);
		chk({3'h0, q}, {3'h0, e[10:3]});
		if (lo_int)
		begin
			bus(1'b0, 1'b0, RD_INT_LO, 8'h00);
			chk({3'h0, q}, {3'h0, e[2:0], 5'h00});
		end
	endtask
	task automatic alert_is(input logic lvl);
		settle();
		chk({10'h0, alert_oe_n}, {10'h0, lvl});
	endtask
	initial
	begin
		void'($urandom(91907));
		// Long enough for four link edges inside reset
		repeat (48) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		chk({5'h0, ideality}, {5'h0, 6'h12});
		repeat (4) @(posedge link_clk_i);
		rem_t = 13'($urandom % 1016);
		int_t = 13'sd323;
		chkcase(1'b0, 1'b1);
		rem_t = 13'sd1100;
		int_t = -13'sd8;
		chkcase(1'b0, 1'b0);
		bus(1'b0, 1'b1, WR_CFG, 8'h04);
		rem_t = -13'sd600;
		int_t = 13'sd1600;
		chkcase(1'b1, 1'b0);
		rem_t = 13'($urandom % 2000) - 13'sd500;
		int_t = 13'($urandom % 1000) | 13'h3;
		chkcase(1'b1, 1'b0);
		bus(1'b0, 1'b1, WR_CFG, 8'h00);
		rem_t = 13'sd720;
		int_t = 13'sd240;
		alert_is(1'b0);
		chk({10'h0, thermal_trip_output_oe_n}, 11'h000);
		bus(1'b1, 1'b0, 8'h00, 8'h00);
		chk({3'h0, q}, {3'h0, SLAVE_ADDR, 1'b0});
		alert_is(1'b0);
		rem_t = 13'sd240;
		alert_is(1'b0);
		bus(1'b1, 1'b0, 8'h00, 8'h00);
		chk({3'h0, q}, {3'h0, SLAVE_ADDR, 1'b0});
		alert_is(1'b1);
		chk({10'h0, thermal_trip_output_oe_n}, 11'h001);
		bus(1'b0, 1'b1, WR_CFG, 8'h80);
		rem_t = 13'sd720;
		alert_is(1'b1);
		bus(1'b0, 1'b1, WR_CFG, 8'ha0);
		alert_is(1'b0);
		rem_t = 13'sd640;
		alert_is(1'b0);
		rem_t = 13'sd560;
		alert_is(1'b1);
		// Low byte must stay frozen across a new result until it is read
		bus(1'b0, 1'b0, RD_REM_HI, 8'h00);
		chk({3'h0, q}, 11'h046);
		rem_t = 13'sd566;
		settle();
		bus(1'b0, 1'b0, RD_REM_LO, 8'h00);
		chk({3'h0, q}, 11'h000);
		bus(1'b0, 1'b0, RD_REM_LO, 8'h00);
		chk({3'h0, q}, 11'h0c0);
		summarize();
	end
endmodule
bind tfa_core tfa_core_assertions #(.CONV_CYC(CONV_CYC)) u_tfa_core_assertions (
	.core_clk_i(core_clk_i),
	.link_clk_i(link_clk_i),
	.sys_rst_i(sys_rst_i),
	.smb_clk_i(smb_clk_i),
	.smb_data_o(smb_data_o),
	.smb_data_oe_n_o(smb_data_oe_n_o),
	.alert_or_second_trip_output_o(alert_or_second_trip_output_o),
	.alert_or_second_trip_output_oe_n_o(alert_or_second_trip_output_oe_n_o),
	.thermal_trip_output_o(thermal_trip_output_o),
	.thermal_trip_output_oe_n_o(thermal_trip_output_oe_n_o),
	.conv_start_o(conv_start_o),
	.ideality_o(ideality_o),
	.adc_done_i(adc_done_i)
);
